// ==== hdl/dmc_channel.sv ====
// transfer channel: moves bytes from a source region to a destination
// region, one read then one write per move, started by software or trigger.
// assumes the link's controller end supplies configuration, the
// instruction-cycle tick, already synchronised triggers and the grant.
`timescale 1ns/1ps
`default_nettype none
module dmc_channel
    import dmc_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    dmc_link_if.chan  link,
    output logic      busy_o,
    output logic      stopped_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SRC_RD,
        ST_DST_WR
    } dmc_state_t;

    dmc_state_t          state;
    logic [NUM_TRIG-1:0] trig_q;
    logic [DATA_W-1:0]   data_hold;
    logic                src_wrapped;
    logic                stopped;
    logic                go;
    logic                start_hit;
    logic                abort_hit;
    logic                over_hit;
    logic                rd_done;
    logic                wr_done;
    logic                msg_done;
    logic                src_last;
    logic                dst_last;

    // rising edge for pulse sources, plain level for held sources
    function automatic logic trig_seen(input logic [SEL_W-1:0] sel);
        trig_seen = link.trig_level[sel] ? link.trig[sel]
                                         : (link.trig[sel] & ~trig_q[sel]);
    endfunction

    function automatic logic [ADDR_W-1:0] step_ptr(input logic [ADDR_W-1:0] ptr,
                                                    input logic [1:0]        mode);
        unique case (mode)
            MODE_INC: step_ptr = ptr + 1'b1;
            MODE_DEC: step_ptr = ptr - 1'b1;
            default:  step_ptr = ptr;
        endcase
    endfunction

    // triggers only count on the tick, once per instruction cycle
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_q <= '0;
        end else if (link.tick) begin
            trig_q <= link.trig;
        end
    end

    assign start_hit = link.tick && link.en && link.start_en
                       && trig_seen(link.start_sel);
    assign abort_hit = link.tick && link.en && link.abort_en
                       && trig_seen(link.abort_sel);
    // a held level would re-fire on every tick while waiting, so only edges count
    assign over_hit  = start_hit && go && !link.trig_level[link.start_sel];

    assign rd_done  = (state == ST_SRC_RD) && link.grant;
    assign wr_done  = (state == ST_DST_WR) && link.grant;
    assign src_last = (link.src_cnt <= 1);
    assign dst_last = (link.dst_cnt <= 1);
    assign msg_done = wr_done && (src_wrapped || dst_last);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            go <= 1'b0;
        end else if (!link.en || abort_hit) begin
            go <= 1'b0;
        end else if ((start_hit || link.sw_go) && !stopped) begin
            go <= 1'b1;
        end else if (msg_done) begin
            go <= 1'b0;
        end
    end

    // stop latch holds until software drops the enable
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stopped <= 1'b0;
        end else if (!link.en) begin
            stopped <= 1'b0;
        end else if (msg_done && ((link.src_stop && src_wrapped)
                                  || (link.dst_stop && dst_last))) begin
            stopped <= 1'b1;
        end
    end

    // overrun only reports; state below ignores it
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
        end else if (!link.en || abort_hit) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE:   if (go && !stopped) begin
                    state <= ST_SRC_RD;
                end
                ST_SRC_RD: if (rd_done) begin
                    state <= ST_DST_WR;
                end
                ST_DST_WR: if (wr_done) begin
                    state <= msg_done ? ST_IDLE : ST_SRC_RD;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_hold <= '0;
        end else if (rd_done) begin
            data_hold <= link.rdata;
        end
    end

    // source side: counts down per read, reloads from size on the read made at a count of one or zero
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.src_ptr <= '0;
            link.src_cnt <= '0;
            src_wrapped  <= 1'b0;
        end else if (!link.en || abort_hit) begin
            link.src_ptr <= link.src_start;
            link.src_cnt <= link.src_size;
            src_wrapped  <= 1'b0;
        end else if (rd_done) begin
            src_wrapped <= src_last;
            if (src_last) begin
                link.src_ptr <= link.src_start;
                link.src_cnt <= link.src_size;
            end else begin
                link.src_ptr <= step_ptr(link.src_ptr, link.src_mode);
                link.src_cnt <= link.src_cnt - 1'b1;
            end
        end else if (wr_done) begin
            src_wrapped <= 1'b0;
        end
    end

    // destination side: same scheme on each write
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.dst_ptr <= '0;
            link.dst_cnt <= '0;
        end else if (!link.en || abort_hit) begin
            link.dst_ptr <= link.dst_start;
            link.dst_cnt <= link.dst_size;
        end else if (wr_done) begin
            if (dst_last) begin
                link.dst_ptr <= link.dst_start;
                link.dst_cnt <= link.dst_size;
            end else begin
                link.dst_ptr <= step_ptr(link.dst_ptr, link.dst_mode);
                link.dst_cnt <= link.dst_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.overrun_evt <= 1'b0;
            link.done_evt    <= 1'b0;
            link.abort_evt   <= 1'b0;
        end else begin
            link.overrun_evt <= over_hit;
            link.done_evt    <= msg_done;
            link.abort_evt   <= abort_hit && go;
        end
    end

    // request held steady while waiting for a free memory cycle
    assign link.req    = (state != ST_IDLE) && !abort_hit && link.en;
    assign link.we     = (state == ST_DST_WR);
    assign link.addr   = (state == ST_DST_WR) ? link.dst_ptr : link.src_ptr;
    assign link.region = (state == ST_DST_WR) ? DST_REGION : link.src_region;
    assign link.wdata  = data_hold;
    assign link.go     = go;
    assign busy_o      = (state != ST_IDLE);
    assign stopped_o   = stopped;
endmodule
`default_nettype wire

// ==== hdl/dmc_ctrl.sv ====
// controller end: wishbone registers for software, instruction-cycle tick,
// trigger pin synchroniser, and the memory arbiter that hands the channel
// cycles the processor leaves idle, or any cycle when the channel outranks it.
// assumes a classic wishbone master and a memory answering in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl
    import dmc_pkg::*;
#(
    parameter logic [NUM_TRIG-1:0] TRIG_LEVEL = LEVEL_SRC
)(
    input  wire logic                core_clk_i,
    input  wire logic                rstn_i,
    dmc_link_if.ctrl                 link,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output logic                     irq_o,
    input  wire logic [NUM_TRIG-1:0] trig_i,
    input  wire logic                cpu_busy_i,
    output logic                     mem_en_o,
    output logic                     mem_we_o,
    output logic      [ADDR_W-1:0]   mem_addr_o,
    output logic      [1:0]          mem_region_o,
    output logic      [DATA_W-1:0]   mem_wdata_o,
    input  wire logic [DATA_W-1:0]   mem_rdata_i
);
    logic [CTRL_W-1:0]   ctrl;
    logic [TRIG_W-1:0]   trig_cfg;
    logic [ST_W-1:0]     status;
    logic [ST_W-1:0]     mask;
    logic [ST_W-1:0]     st_set;
    logic [ST_W-1:0]     st_clr;
    logic [NUM_TRIG-1:0] trig_m;
    logic [NUM_TRIG-1:0] trig_s;
    logic [TICK_W-1:0]   tick_cnt;
    logic [31:0]         rd_word;
    logic                wr_hit;
    logic                sw_go;

    // refuse a divider that the tick counter cannot count out
    if (INSTR_CLKS != (1 << TICK_W) || CLK_HZ <= 0) begin
        $error("instruction divider does not match its counter width");
    end

    assign wr_hit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

    // ack one cycle after the request; writes land on the ack edge
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= RESET_WORD;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_word;
        end
    end

    always_comb begin
        rd_word = RESET_WORD;
        unique case (wb_adr_i)
            OFS_CTRL: begin
                rd_word[CTRL_W-1:0] = ctrl;
                rd_word[CTRL_GO]    = link.go;
            end
            OFS_SRC_START: rd_word[ADDR_W-1:0] = link.src_start;
            OFS_DST_START: rd_word[ADDR_W-1:0] = link.dst_start;
            OFS_SRC_SIZE:  rd_word[CNT_W-1:0]  = link.src_size;
            OFS_DST_SIZE:  rd_word[CNT_W-1:0]  = link.dst_size;
            OFS_TRIG:      rd_word[TRIG_W-1:0] = trig_cfg;
            OFS_STATUS:    rd_word[ST_W-1:0]   = status;
            OFS_MASK:      rd_word[ST_W-1:0]   = mask;
            OFS_SRC_PTR:   rd_word[ADDR_W-1:0] = link.src_ptr;
            OFS_DST_PTR:   rd_word[ADDR_W-1:0] = link.dst_ptr;
            OFS_SRC_CNT:   rd_word[CNT_W-1:0]  = link.src_cnt;
            OFS_DST_CNT:   rd_word[CNT_W-1:0]  = link.dst_cnt;
            default:       rd_word             = RESET_WORD;
        endcase
    end

    // configuration words; software sets these before the enable
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl           <= '0;
            trig_cfg       <= '0;
            mask           <= '0;
            link.src_start <= '0;
            link.dst_start <= '0;
            link.src_size  <= '0;
            link.dst_size  <= '0;
        end else if (wr_hit) begin
            unique case (wb_adr_i)
                OFS_CTRL:      ctrl           <= wb_dat_i[CTRL_W-1:0];
                OFS_SRC_START: link.src_start <= wb_dat_i[ADDR_W-1:0];
                OFS_DST_START: link.dst_start <= wb_dat_i[ADDR_W-1:0];
                OFS_SRC_SIZE:  link.src_size  <= wb_dat_i[CNT_W-1:0];
                OFS_DST_SIZE:  link.dst_size  <= wb_dat_i[CNT_W-1:0];
                OFS_TRIG:      trig_cfg       <= wb_dat_i[TRIG_W-1:0];
                OFS_MASK:      mask           <= wb_dat_i[ST_W-1:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sw_go <= 1'b0;
        end else begin
            sw_go <= wr_hit && (wb_adr_i == OFS_CTRL) && wb_dat_i[CTRL_GO];
        end
    end

    // sticky events: a set in the clearing cycle survives
    assign st_set = {link.abort_evt, link.done_evt, link.overrun_evt};
    assign st_clr = (wr_hit && wb_adr_i == OFS_STATUS) ? wb_dat_i[ST_W-1:0] : '0;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status <= '0;
        end else begin
            status <= (status & ~st_clr) | st_set;
        end
    end
    assign irq_o = |(status & mask);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_m <= '0;
            trig_s <= '0;
        end else begin
            trig_m <= trig_i;
            trig_s <= trig_m;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    assign link.tick       = (tick_cnt == '1);
    assign link.trig       = trig_s;
    assign link.trig_level = TRIG_LEVEL;
    assign link.sw_go      = sw_go;
    assign link.en         = ctrl[CTRL_EN];
    assign link.src_stop   = ctrl[CTRL_SSTOP];
    assign link.dst_stop   = ctrl[CTRL_DSTOP];
    assign link.src_region = ctrl[CTRL_REGION +: 2];
    assign link.src_mode   = ctrl[CTRL_SOURCE_ADDR_MODE +: 2];
    assign link.dst_mode   = ctrl[CTRL_DEST_ADDR_MODE +: 2];
    assign link.start_sel  = trig_cfg[TRIG_SSEL +: SEL_W];
    assign link.start_en   = trig_cfg[TRIG_SEN];
    assign link.abort_sel  = trig_cfg[TRIG_ASEL +: SEL_W];
    assign link.abort_en   = trig_cfg[TRIG_AEN];

    // no grant until priorities are locked; then idle processor cycles, or
    // any cycle when the channel outranks the processor
    assign link.grant = link.req && ctrl[CTRL_LOCK]
                        && (!cpu_busy_i || ctrl[CTRL_PRIO +: 3] < CPU_PRIO);
    assign link.rdata = mem_rdata_i;
    assign mem_en_o     = link.grant;
    assign mem_we_o     = link.we;
    assign mem_addr_o   = link.addr;
    assign mem_region_o = link.region;
    assign mem_wdata_o  = link.wdata;
endmodule
`default_nettype wire

// ==== hdl/dmc_link_if.sv ====
// link between the transfer channel and its controller / arbiter end.
// assumes both ends run on the same core clock; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface dmc_link_if
    import dmc_pkg::*;
();
    logic                en;
    logic                src_stop;
    logic                dst_stop;
    logic [1:0]          src_region;
    logic [1:0]          src_mode;
    logic [1:0]          dst_mode;
    logic [ADDR_W-1:0]   src_start;
    logic [ADDR_W-1:0]   dst_start;
    logic [CNT_W-1:0]    src_size;
    logic [CNT_W-1:0]    dst_size;
    logic [SEL_W-1:0]    start_sel;
    logic [SEL_W-1:0]    abort_sel;
    logic                start_en;
    logic                abort_en;
    logic                sw_go;
    logic                tick;
    logic [NUM_TRIG-1:0] trig;
    logic [NUM_TRIG-1:0] trig_level;
    logic                grant;
    logic [DATA_W-1:0]   rdata;
    logic                req;
    logic                we;
    logic [ADDR_W-1:0]   addr;
    logic [1:0]          region;
    logic [DATA_W-1:0]   wdata;
    logic                go;
    logic                overrun_evt;
    logic                done_evt;
    logic                abort_evt;
    logic [ADDR_W-1:0]   src_ptr;
    logic [ADDR_W-1:0]   dst_ptr;
    logic [CNT_W-1:0]    src_cnt;
    logic [CNT_W-1:0]    dst_cnt;

    modport chan (
        input  en, src_stop, dst_stop, src_region, src_mode, dst_mode, src_start, dst_start,
               src_size, dst_size, start_sel, abort_sel, start_en, abort_en, sw_go, tick,
               trig, trig_level, grant, rdata,
        output req, we, addr, region, wdata, go, overrun_evt, done_evt, abort_evt,
               src_ptr, dst_ptr, src_cnt, dst_cnt
    );
    modport ctrl (
        output en, src_stop, dst_stop, src_region, src_mode, dst_mode, src_start, dst_start,
               src_size, dst_size, start_sel, abort_sel, start_en, abort_en, sw_go, tick,
               trig, trig_level, grant, rdata,
        input  req, we, addr, region, wdata, go, overrun_evt, done_evt, abort_evt,
               src_ptr, dst_ptr, src_cnt, dst_cnt
    );
endinterface
`default_nettype wire

// ==== hdl/dmc_pkg.sv ====
// shared constants of the single-channel memory mover and its controller.
// assumes one 25 MHz core clock shared by both ends.
package dmc_pkg;
    localparam int ADDR_W     = 16;
    localparam int CNT_W      = 12;
    localparam int NUM_TRIG   = 8;
    localparam int SEL_W      = 3;
    localparam int DATA_W     = 8;

    // core clocks per instruction cycle; triggers are looked at once per cycle
    localparam int CLK_HZ     = 25_000_000;
    localparam int INSTR_CLKS = 4;
    localparam int TICK_W     = 2;

    // address modes of either pointer
    localparam logic [1:0] MODE_HOLD = 2'h0;
    localparam logic [1:0] MODE_INC  = 2'h1;
    localparam logic [1:0] MODE_DEC  = 2'h2;
    localparam logic [1:0] DST_REGION = 2'h0;

    // wishbone register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_SRC_START = 8'h04;
    localparam logic [7:0] OFS_DST_START = 8'h08;
    localparam logic [7:0] OFS_SRC_SIZE  = 8'h0c;
    localparam logic [7:0] OFS_DST_SIZE  = 8'h10;
    localparam logic [7:0] OFS_TRIG      = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_MASK      = 8'h1c;
    localparam logic [7:0] OFS_SRC_PTR   = 8'h20;
    localparam logic [7:0] OFS_DST_PTR   = 8'h24;
    localparam logic [7:0] OFS_SRC_CNT   = 8'h28;
    localparam logic [7:0] OFS_DST_CNT   = 8'h2c;

    // control register fields
    localparam int CTRL_EN       = 0;
    localparam int CTRL_GO       = 1;
    localparam int CTRL_SSTOP    = 2;
    localparam int CTRL_DSTOP    = 3;
    localparam int CTRL_REGION   = 4;
    localparam int CTRL_SOURCE_ADDR_MODE    = 6;
    localparam int CTRL_DEST_ADDR_MODE    = 8;
    localparam int CTRL_LOCK     = 10;
    localparam int CTRL_PRIO     = 11;
    localparam int CTRL_W        = 14;

    // trigger select register fields
    localparam int TRIG_SSEL     = 0;
    localparam int TRIG_SEN      = 3;
    localparam int TRIG_ASEL     = 4;
    localparam int TRIG_AEN      = 7;
    localparam int TRIG_W        = 8;

    // status / mask bits
    localparam int ST_OVERRUN    = 0;
    localparam int ST_DONE       = 1;
    localparam int ST_ABORT      = 2;
    localparam int ST_W          = 3;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // trigger sources 0..3 hold their request until served; 4..7 pulse
    localparam logic [7:0]  LEVEL_SRC  = 8'h0f;
    // processor priority level; lower number wins
    localparam logic [2:0]  CPU_PRIO   = 3'h3;
endpackage

// ==== verif/dmc_link_chk.sv ====
// assertions on the link between the transfer channel and its controller end.
// assumes one core clock and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dmc_link_chk
    import dmc_pkg::*;
(
    input wire logic                core_clk_i,
    input wire logic                rstn_i,
    input wire logic [1:0]          src_region,
    input wire logic [1:0]          dst_mode,
    input wire logic [SEL_W-1:0]    start_sel,
    input wire logic                start_en,
    input wire logic                tick,
    input wire logic [NUM_TRIG-1:0] trig_level,
    input wire logic                grant,
    input wire logic                req,
    input wire logic                we,
    input wire logic [1:0]          region,
    input wire logic                go,
    input wire logic                overrun_evt,
    input wire logic                abort_evt,
    input wire logic [ADDR_W-1:0]   dst_ptr,
    input wire logic [CNT_W-1:0]    src_cnt,
    input wire logic [CNT_W-1:0]    dst_cnt
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    ovr_while_busy_a: assert property (overrun_evt |-> $past(go))
        else $error("overrun flagged while idle");
    ovr_keeps_go_a: assert property (overrun_evt && !abort_evt |-> go)
        else $error("overrun stopped the message");
    ovr_edge_only_a: assert property (overrun_evt |-> $past(start_en && !trig_level[start_sel]))
        else $error("overrun from a level source");
    tick_period_a: assert property (tick |=> !tick [*3] ##1 tick)
        else $error("trigger sampling tick off period");
    region_sel_a: assert property (req |-> region == (we ? DST_REGION : src_region))
        else $error("wrong region on request");
    dst_step_a: assert property (req && grant && we && dst_mode == MODE_INC && dst_cnt > 1 && !tick
        |=> dst_ptr == $past(dst_ptr) + 16'h0001) else $error("dest pointer did not advance");
    src_count_a: assert property (req && grant && !we && src_cnt > 1 && !tick
        |=> src_cnt == $past(src_cnt) - 12'h001) else $error("source count did not step");
    move_order_a: assert property (req && grant && !we ##1 !tick |-> req && we)
        else $error("read not followed by write");
    req_needs_go_a: assert property (req |-> go)
        else $error("memory request without go");

    cover property (overrun_evt);
    cover property (req && we && grant);
    cover property ((req && !grant) [*4]);
    cover property (abort_evt);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// bench: controller and channel joined by the link, driven over wishbone.
// assumes a memory answering in the same cycle and a randomly busy cpu.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dmc_pkg::*;
    logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, cb = 0, hold = 0, slow = 0;
    logic        ack, irq, busy, stp, men, mwe;
    logic [7:0]  adr = 0, trig = 0, rd, mwd;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wd = 0, dto, q, seed = 32'h0000_cf96, cs = 32'h0000_cf96;
    logic [15:0] ma;
    logic [1:0]  mr, rg;
    logic [2:0]  pr, s;
    logic [23:0] wq[$];
    int          n_fail = 0, n_tests = 0, cyc_n = 0;

    assign rd = ma[7:0] ^ 8'h5a;
    dmc_link_if lk ();
    dmc_channel dmc_channel_inst (.core_clk_i(clk), .rstn_i(rstn), .link(lk), .busy_o(busy),
        .stopped_o(stp));
    dmc_ctrl dmc_ctrl_inst (.core_clk_i(clk), .rstn_i(rstn), .link(lk), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(dto), .wb_ack_o(ack), .irq_o(irq), .trig_i(trig), .cpu_busy_i(cb),
        .mem_en_o(men), .mem_we_o(mwe), .mem_addr_o(ma), .mem_region_o(mr),
        .mem_wdata_o(mwd), .mem_rdata_i(rd));
    dmc_link_chk dmc_link_chk_inst (.core_clk_i(clk), .rstn_i(rstn), .src_region(lk.src_region),
        .dst_mode(lk.dst_mode), .start_sel(lk.start_sel), .start_en(lk.start_en), .tick(lk.tick),
        .trig_level(lk.trig_level), .grant(lk.grant), .req(lk.req), .we(lk.we),
        .region(lk.region), .go(lk.go), .overrun_evt(lk.overrun_evt), .abort_evt(lk.abort_evt),
        .dst_ptr(lk.dst_ptr), .src_cnt(lk.src_cnt), .dst_cnt(lk.dst_cnt));

    initial begin
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [15:0] step(input logic [15:0] b, input logic [1:0] m, input int i);
        return m == MODE_INC ? b + 16'(i) : m == MODE_DEC ? b - 16'(i) : b;
    endfunction

    function automatic logic [31:0] cw(input logic [1:0] sm, dm, input logic g, ss);
        return 32'(1) << CTRL_EN | 32'(g) << CTRL_GO | 32'(ss) << CTRL_SSTOP
            | 32'(rg) << CTRL_REGION | 32'(sm) << CTRL_SOURCE_ADDR_MODE | 32'(dm) << CTRL_DEST_ADDR_MODE
            | 32'(1) << CTRL_LOCK | 32'(pr) << CTRL_PRIO;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = dto;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic drain(input int n);
        while (wq.size() < n) @(posedge clk);
        while (lk.go !== 1'b0) @(posedge clk);
        chk(32'(busy), 32'h0000_0000);
    endtask

    task automatic moves(input logic [1:0] sm, dm, input int k);
        logic [23:0] e;
        logic [15:0] sa;
        for (int i = 0; i < 2; i++) begin
            e = wq.pop_front();
            sa = step(16'h0100, sm, i);
            chk(32'(e), {8'h00, step(16'h0200, dm, k + i), sa[7:0] ^ 8'h5a});
        end
    endtask

    task automatic pulse(input logic [2:0] p, input int n);
        trig[p] <= 1'b1;
        repeat (n) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cs <= xs(cs);
        cb <= hold | cs[9];
        cyc_n <= cyc_n + 1;
        if (lk.req && men && mwe)
            wq.push_back({ma, mwd});
        if (lk.req && men)
            chk(32'(mr), mwe ? 32'(DST_REGION) : 32'(rg));
        if (lk.req && men && cb && slow)
            chk(32'h0000_0001, 32'h0000_0000);
        if (cyc_n == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        wb(0, OFS_CTRL, 0);
        chk(q, 32'h0000_0000);
        wb(0, 8'h30, 0);
        wb(1, OFS_SRC_START, 32'h0000_0100);
        wb(1, OFS_DST_START, 32'h0000_0200);
        wb(1, OFS_SRC_SIZE, 32'h0000_0002);
        wb(1, OFS_DST_SIZE, 32'h0000_0004);
        wb(1, OFS_MASK, 32'h0000_0003);
        // every mode on each side; two messages walk the whole destination
        for (logic [1:0] m = 2'h0; m != 2'h3; m++) begin
            seed = xs(seed);
            rg = seed[1:0];
            pr = seed[4:2];
            slow = pr >= CPU_PRIO;
            wb(1, OFS_CTRL, 0);
            wb(1, OFS_CTRL, cw(m, 2'h2 - m, 0, 0));
            for (int k = 0; k < 4; k += 2) begin
                wb(1, OFS_CTRL, cw(m, 2'h2 - m, 1, 0));
                drain(2);
                moves(m, 2'h2 - m, k);
            end
            wb(0, OFS_DST_PTR, 0);
            chk(q, 32'h0000_0200);
            wb(0, OFS_SRC_CNT, 0);
            chk(q, 32'h0000_0002);
        end
        wb(0, OFS_STATUS, 0);
        chk(32'(q[ST_DONE]), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        wb(1, OFS_STATUS, 32'h0000_0007);
        @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        wb(1, OFS_MASK, 0);
        pr = 3'h7;
        slow = 1'b1;
        // stall the channel behind a busy cpu, then start it twice
        for (int lv = 0; lv < 2; lv++) begin
            seed = xs(seed);
            s = lv == 1 ? {1'b0, seed[1:0]} : {1'b1, seed[1:0]};
            hold <= 1'b1;
            wb(1, OFS_CTRL, 0);
            wb(1, OFS_STATUS, 32'h0000_0007);
            wb(1, OFS_TRIG, {24'h0, 1'b1, s ^ 3'h2, 1'b1, s});
            wb(1, OFS_CTRL, cw(2'h1, 2'h1, 0, 0));
            pulse(s, 8);
            trig[s] <= 1'b0;
            repeat (8) @(posedge clk);
            pulse(s, 8);
            if (lv == 0)
                trig[s] <= 1'b0;
            repeat (8) @(posedge clk);
            wb(0, OFS_STATUS, 0);
            chk(32'(q[ST_OVERRUN]), 32'(lv == 0));
            chk(32'(irq), 32'h0000_0000);
            wb(0, OFS_CTRL, 0);
            chk(32'(q[CTRL_GO]), 32'h0000_0001);
            trig <= 8'h00;
            hold <= 1'b0;
            drain(2);
            moves(2'h1, 2'h1, 0);
        end
        // abort a message stalled behind the cpu: nothing may move
        hold <= 1'b1;
        wb(1, OFS_CTRL, cw(2'h1, 2'h1, 1, 0));
        pulse(s ^ 3'h2, 8);
        trig <= 8'h00;
        hold <= 1'b0;
        chk(32'(lk.go), 32'h0000_0000);
        wb(0, OFS_STATUS, 0);
        chk(32'(q[ST_ABORT]), 32'h0000_0001);
        chk(32'(wq.size()), 32'h0000_0000);
        wb(1, OFS_CTRL, 0);
        wb(1, OFS_CTRL, cw(2'h1, 2'h1, 0, 1));
        wb(1, OFS_CTRL, cw(2'h1, 2'h1, 1, 1));
        drain(2);
        moves(2'h1, 2'h1, 0);
        wb(1, OFS_CTRL, cw(2'h1, 2'h1, 1, 1));
        repeat (12) @(posedge clk);
        chk(32'(wq.size()), 32'h0000_0000);
        chk(32'(stp), 32'h0000_0001);
        wrap_up();
    end
endmodule
`default_nettype wire
